//--- rtl/autozero_if.sv
// link between trim controller and autozero scheduler
`timescale 1ns/1ps
interface autozero_if;
   logic cycle_tick;
   logic [7:0] setting;
   logic setting_wr;
   logic zero_pulse;
   modport sched (input cycle_tick, input setting, input setting_wr,
                  output zero_pulse);
   modport ctrl (output cycle_tick, output setting, output setting_wr,
                 input zero_pulse);
endinterface

//--- rtl/autozero_sched.sv
// autozero scheduler for the ambient light pulse counter
`timescale 1ns/1ps
module autozero_sched
   import trim_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   autozero_if.sched az
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic armed;
      logic pulse;
   } az_s;
   az_s az_ff;
   az_s nxt_az;

   assign az.zero_pulse = az_ff.pulse;

   // count measurement cycles and pulse on the chosen one
   always_comb
   begin
      nxt_az = az_ff;
      nxt_az.pulse = 1'b0;
      if (az.setting_wr)
      begin
         nxt_az.cnt = 8'h00;
         nxt_az.armed = 1'b1; // a new setting rearms the one-shot
      end
      else if (az.cycle_tick)
      begin
         case (az.setting)
            AZ_NEVER:
               nxt_az.cnt = 8'h00; // RQ1
            AZ_ONCE:
               if (az_ff.armed) // RQ1
               begin
                  nxt_az.pulse = 1'b1;
                  nxt_az.armed = 1'b0;
               end
            default:
               if (az_ff.cnt >= az.setting - 8'h01) // RQ1
               begin
                  nxt_az.pulse = 1'b1;
                  nxt_az.cnt = 8'h00;
               end
               else
                  nxt_az.cnt = az_ff.cnt + 8'h01;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         az_ff <= '{cnt: 8'h00, armed: 1'b1, pulse: 1'b0};
      else
         az_ff <= nxt_az;
   end
endmodule

//--- rtl/prox_offset_trim_sequencer.sv
// apb register file and offset trim sequencer
`timescale 1ns/1ps
module prox_offset_trim_sequencer
   import trim_pkg::*;
#(
   parameter logic [13:0] SEARCH_TARGET = 14'h0100
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [9:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_cycle_start,
   input wire logic i_meas_valid,
   input wire logic [3:0][13:0] i_meas_chan,
   input wire logic [15:0] i_meas_prox,
   output logic o_meas_req,
   output logic o_meas_electrical,
   output logic [3:0][8:0] o_offset,
   output logic [15:0] o_baseline,
   output logic o_autozero,
   output logic o_trim_irq
);
   typedef struct packed
   {
      // sequencer state
      trim_e state;
      // apb answer
      logic ready;
      logic [7:0] rdata;
      logic slverr;
      // software visible registers and flags
      logic [7:0] az_setting;
      logic start;
      logic [7:0] cfg;
      logic [3:0][8:0] offs;
      logic [15:0] baseline;
      logic done;
      logic lowered;
      logic irq_en;
      logic irq;
      // sequencer working values
      logic meas_req;
      logic elec;
      logic auto_lower;
      logic [2:0] avg_sel;
      logic [2:0] bitpos;
      logic [22:0] acc;
      logic [7:0] scnt;
   } top_s;

   // reset image of the whole state, averaging count at four
   localparam top_s TOP_RESET = '{
      state: TRIM_IDLE,
      ready: 1'b0,
      rdata: 8'h00,
      slverr: 1'b0,
      az_setting: AZ_RESET,
      start: 1'b0,
      cfg: CFG_RESET, // RQ13
      offs: '0,
      baseline: 16'h0000,
      done: 1'b0,
      lowered: 1'b0,
      irq_en: 1'b0,
      irq: 1'b0,
      meas_req: 1'b0,
      elec: 1'b0,
      auto_lower: 1'b0,
      avg_sel: 3'h0,
      bitpos: 3'h0,
      acc: 23'h000000,
      scnt: 8'h00
   };

   top_s r_ff;
   top_s nxt_r;
   // bus decode and sequencer helpers
   logic [7:0] idx;
   logic in_access;
   logic wr_ok;
   logic az_wr;
   logic start_req;
   logic stop_req;
   logic [22:0] acc_sum;
   logic [7:0] scnt_inc;
   logic busy;
   logic ctrl_wr;
   logic cfg_wr;
   logic irq_en_wr;
   logic status_wr;
   logic offset_wr;
   autozero_if az ();

   // high byte of an offset word is the sign spread over eight bits
   function automatic logic [7:0] sign_byte(input offset_t v);
      sign_byte = {8{v[8]}}; // RQ14
   endfunction

   // lower an offset by one without passing the negative limit
   function automatic offset_t lower_offset(input offset_t v);
      lower_offset = (v > OFFSET_MIN) ? offset_t'(v - 9'sd1) : v;
   endfunction

   // sample count selected by the averaging field
   function automatic logic [7:0] avg_samples(input logic [2:0] v);
      avg_samples = 8'h01 << v; // RQ12
   endfunction

   // does an index fall on an offset byte
   function automatic logic is_offset_idx(input logic [7:0] a);
      is_offset_idx = a >= IDX_OFFSET_FIRST && a <= IDX_OFFSET_LAST;
   endfunction

   // state after the search, or straight after start when it is skipped
   function automatic trim_e after_search(input logic [2:0] avg);
      after_search = (avg == 3'h0) ? TRIM_FINISH : AVG_REQ; // RQ12
   endfunction

   // does an index hit a register
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = is_offset_idx(a) ||
                  a == IDX_BASELINE_LO || a == IDX_BASELINE_HI ||
                  a == IDX_AZ || a == IDX_CTRL || a == IDX_CFG ||
                  a == IDX_STATUS || a == IDX_IRQ_EN;
   endfunction

   // read mux, reserved bits read as zero
   function automatic logic [7:0] read_reg(input logic [7:0] a,
                                           input top_s s);
      logic [7:0] d;
      d = 8'h00;
      if (is_offset_idx(a))
      begin
         if (a[0])
            d = sign_byte(s.offs[a[2:1]]); // RQ14
         else
            d = s.offs[a[2:1]][7:0];
      end
      else
         case (a)
            IDX_BASELINE_LO: d = s.baseline[7:0];
            IDX_BASELINE_HI: d = s.baseline[15:8];
            IDX_AZ: d = s.az_setting;
            IDX_CTRL: d[CTRL_START_BIT] = s.start;
            IDX_CFG: d = s.cfg;
            IDX_STATUS:
            begin
               d[ST_DONE_BIT] = s.done;
               d[ST_LOWERED_BIT] = s.lowered;
               d[ST_BUSY_BIT] = s.state != TRIM_IDLE;
            end
            IDX_IRQ_EN: d[IRQ_EN_BIT] = s.irq_en;
            default: d = 8'h00;
         endcase
      return d;
   endfunction

   // bus decode shared by the register and sequencer logic
   assign idx = i_paddr[9:2];
   assign in_access = i_psel & i_penable;
   assign wr_ok = in_access & r_ff.ready & i_pwrite & ~r_ff.slverr;
   assign busy = r_ff.state != TRIM_IDLE;
   // one write strobe per writable register, one shared by all offset bytes, high in the cycle the write lands
   assign az_wr = wr_ok && idx == IDX_AZ;
   assign ctrl_wr = wr_ok && idx == IDX_CTRL;
   assign cfg_wr = wr_ok && idx == IDX_CFG;
   assign irq_en_wr = wr_ok && idx == IDX_IRQ_EN;
   assign status_wr = wr_ok && idx == IDX_STATUS;
   assign offset_wr = wr_ok && is_offset_idx(idx) && !busy;
   assign start_req = ctrl_wr && i_pwdata[CTRL_START_BIT];
   assign stop_req = ctrl_wr && !i_pwdata[CTRL_START_BIT];
   assign acc_sum = r_ff.acc + {7'h00, i_meas_prox};
   assign scnt_inc = r_ff.scnt + 8'h01;

   // autozero scheduler hookup
   assign az.cycle_tick = i_cycle_start;
   assign az.setting = r_ff.az_setting;
   assign az.setting_wr = az_wr;
   autozero_sched u_autozero
   (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .az(az.sched)
   );

   // next state: apb slave, register writes, trim sequence
   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.meas_req = 1'b0;
      // one wait state: read data and error are captured first
      if (in_access && !r_ff.ready)
      begin
         nxt_r.ready = 1'b1;
         nxt_r.rdata = read_reg(idx, r_ff);
         nxt_r.slverr = !is_mapped(idx) || i_paddr[1:0] != 2'b00;
      end
      else
      begin
         nxt_r.ready = 1'b0;
         nxt_r.slverr = 1'b0;
      end
      // plain configuration writes
      if (az_wr)
         nxt_r.az_setting = i_pwdata[7:0];
      if (cfg_wr)
         nxt_r.cfg = i_pwdata[7:0] & CFG_WRITABLE;
      if (irq_en_wr)
         nxt_r.irq_en = i_pwdata[IRQ_EN_BIT];

      // write one to clear, hardware sets below take priority
      if (status_wr)
      begin
         if (i_pwdata[ST_DONE_BIT])
            nxt_r.done = 1'b0;
         if (i_pwdata[ST_LOWERED_BIT])
            nxt_r.lowered = 1'b0;
      end

      // software offset writes only while the sequencer is idle
      if (offset_wr)
      begin
         if (idx[0])
            nxt_r.offs[idx[2:1]][8] = i_pwdata[7]; // RQ14
         else
            nxt_r.offs[idx[2:1]][7:0] = i_pwdata[7:0];
      end

      // trim sequence
      case (r_ff.state)
         TRIM_IDLE:
            if (start_req) // RQ2
            begin
               // mode bits and count are latched for the whole run
               nxt_r.start = 1'b1;
               nxt_r.elec = r_ff.cfg[CFG_ELEC_BIT]; // RQ8 RQ9
               nxt_r.auto_lower = r_ff.cfg[CFG_AUTO_LOWER_BIT];
               nxt_r.avg_sel = r_ff.cfg[CFG_AVG_LSB +: 3];
               nxt_r.acc = 23'h000000;
               nxt_r.scnt = 8'h00;
               if (!r_ff.cfg[CFG_SKIP_BIT])
               begin
                  nxt_r.offs = '0;
                  nxt_r.bitpos = SEARCH_TOP_BIT;
                  nxt_r.state = SEARCH_REQ;
               end
               else
                  nxt_r.state = after_search(nxt_r.avg_sel); // RQ10 RQ12
            end
         SEARCH_REQ:
         begin
            // try the next offset bit on every channel at once
            for (int c = 0; c < NUM_CHAN; c++)
               nxt_r.offs[c][r_ff.bitpos] = 1'b1;
            nxt_r.meas_req = 1'b1;
            nxt_r.state = SEARCH_WAIT;
         end
         SEARCH_WAIT:
            if (i_meas_valid)
            begin
               // keep the bit only while crosstalk is still at or above target
               for (int c = 0; c < NUM_CHAN; c++)
                  if (i_meas_chan[c] < SEARCH_TARGET)
                     nxt_r.offs[c][r_ff.bitpos] = 1'b0; // RQ3
               if (r_ff.bitpos != 3'h0)
               begin
                  nxt_r.bitpos = r_ff.bitpos - 3'h1;
                  nxt_r.state = SEARCH_REQ;
               end
               else
                  nxt_r.state = after_search(r_ff.avg_sel); // RQ11 RQ12
            end
         AVG_REQ:
         begin
            nxt_r.meas_req = 1'b1;
            nxt_r.state = AVG_WAIT;
         end
         AVG_WAIT:
            if (i_meas_valid)
            begin
               nxt_r.acc = acc_sum;
               nxt_r.scnt = scnt_inc;
               // zero result lowers that channel; averaging carries on
               for (int c = 0; c < NUM_CHAN; c++)
                  if (r_ff.auto_lower && i_meas_chan[c] == 14'h0000)
                  begin
                     nxt_r.offs[c] = lower_offset(r_ff.offs[c]); // RQ6
                     nxt_r.lowered = 1'b1; // RQ6 RQ7
                  end
               if (scnt_inc == avg_samples(r_ff.avg_sel)) // RQ12
               begin
                  nxt_r.baseline = 16'(acc_sum >> r_ff.avg_sel); // RQ15
                  nxt_r.state = TRIM_FINISH;
               end
               else
                  nxt_r.state = AVG_REQ;
            end
         TRIM_FINISH:
         begin
            nxt_r.start = 1'b0; // RQ16
            nxt_r.done = 1'b1; // RQ4
            nxt_r.state = TRIM_IDLE;
         end
         default:
            nxt_r.state = TRIM_IDLE;
      endcase

      // abort from any busy state but the last one
      if (stop_req && busy && r_ff.state != TRIM_FINISH) // RQ5
      begin
         nxt_r.start = 1'b0; // RQ16
         nxt_r.meas_req = 1'b0;
         nxt_r.state = TRIM_IDLE;
      end

      // interrupt level follows done flag and its enable
      nxt_r.irq = nxt_r.done & nxt_r.irq_en; // RQ4
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         r_ff <= TOP_RESET; // RQ13
      else
         r_ff <= nxt_r;
   end

   // outputs straight from the state register
   assign o_pready = r_ff.ready;
   assign o_prdata = {24'h000000, r_ff.rdata};
   assign o_pslverr = r_ff.slverr;

   // sequencer and autozero outputs
   assign o_meas_req = r_ff.meas_req;
   assign o_meas_electrical = r_ff.elec; // RQ8 RQ9
   assign o_offset = r_ff.offs;
   assign o_baseline = r_ff.baseline;
   assign o_autozero = az.zero_pulse;
   assign o_trim_irq = r_ff.irq;
endmodule

//--- rtl/trim_pkg.sv
// constants and types for the offset trim sequencer
// Functional notes
// [RQ1] autozero setting: 0 never, N every N, 255 once
// [RQ2] writing start bit 1 launches trim
// [RQ3] trim results land in offset words C0-C7
// [RQ4] completion sets done flag, irq if enabled
// [RQ5] writing start bit 0 while running aborts
// [RQ6] zero sample while averaging lowers offset, flags
// [RQ7] averaging never restarts after an offset lowering
// [RQ8] electrical mode trims without optical measurement
// [RQ9] electrical bit clear measures optical plus electrical
// [RQ10] search skip bit omits the binary search
// [RQ11] averaging runs only after search finishes; with search skipped, code averages right after start
// [RQ12] averaging count: 0 skips, else two^v samples
// [RQ13] averaging count resets to 4
// [RQ14] offsets 9-bit signed, high byte 00 or FF
// [RQ15] trim end loads stored baseline with average
// [RQ16] start bit self-clears on completion or abort
package trim_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_OFFSET_FIRST = 8'hC0;
   localparam logic [7:0] IDX_OFFSET_LAST = 8'hC7;
   localparam logic [7:0] IDX_BASELINE_LO = 8'hD2;
   localparam logic [7:0] IDX_BASELINE_HI = 8'hD3;
   localparam logic [7:0] IDX_AZ = 8'hD6;
   localparam logic [7:0] IDX_CTRL = 8'hD7;
   localparam logic [7:0] IDX_CFG = 8'hD8;
   localparam logic [7:0] IDX_STATUS = 8'hE0;
   localparam logic [7:0] IDX_IRQ_EN = 8'hE1;
   // field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CFG_AUTO_LOWER_BIT = 6;
   localparam int CFG_ELEC_BIT = 4;
   localparam int CFG_SKIP_BIT = 3;
   localparam int CFG_AVG_LSB = 0;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_LOWERED_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int IRQ_EN_BIT = 0;
   localparam logic [7:0] CFG_WRITABLE = 8'h5F;
   // reset values
   localparam logic [7:0] AZ_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h04;
   // autozero encodings
   localparam logic [7:0] AZ_NEVER = 8'h00;
   localparam logic [7:0] AZ_ONCE = 8'hFF;
   // offset limits and search shape
   localparam logic signed [8:0] OFFSET_MIN = -9'sd255;
   localparam logic [2:0] SEARCH_TOP_BIT = 3'h7;
   localparam int NUM_CHAN = 4;
   typedef logic signed [8:0] offset_t;
   typedef enum logic [2:0]
   {
      TRIM_IDLE, SEARCH_REQ, SEARCH_WAIT, AVG_REQ, AVG_WAIT, TRIM_FINISH
   } trim_e;
endpackage

//--- verif/tb.sv
// register level testbench for the offset trim sequencer
`timescale 1ns/1ps
module tb;
   import trim_pkg::*;
   logic i_clk = 0;
   logic i_rstn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic cyc = 0;
   logic mvalid = 0;
   logic [15:0] nreq = '0;
   logic [15:0] azc = '0;
   logic [15:0] a0;
   logic [1:0] pend = '0;
   logic elec_seen = 0;
   logic pready, pslverr, mreq, melec, az, irq, er;
   logic [31:0] prdata;
   logic [3:0][8:0] offs;
   logic [15:0] base;
   logic [7:0] rdv;
   logic [23:0] azt [4] = '{24'h030702, 24'hFF0401, 24'h000500, 24'h010303};
   logic [7:0] offx [8] = '{8'hFE, 8'hFF, 8'hFF, 8'h00, 8'hFE, 8'hFF,
      8'hFF, 8'h00};
   int mismatches = 0;
   int n_checks = 0;

   prox_offset_trim_sequencer #(.SEARCH_TARGET(14'h0100))
      prox_offset_trim_sequencer_inst (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_cycle_start(cyc),
      .i_meas_valid(mvalid),
      .i_meas_chan({14'h3FFF, 14'h0000, 14'h3FFF, 14'h0000}),
      .i_meas_prox(nreq), .o_meas_req(mreq), .o_meas_electrical(melec),
      .o_offset(offs), .o_baseline(base), .o_autozero(az),
      .o_trim_irq(irq));

   always #20 i_clk = ~i_clk;

   // measurement responder, answers four cycles after each request
   always @(posedge i_clk)
   begin
      mvalid <= 1'b0;
      azc <= azc + {15'h0, az === 1'b1};
      if (mreq === 1'b1)
      begin
         nreq <= nreq + 16'h1;
         elec_seen <= melec;
         pend <= 2'h3;
      end
      else if (pend != 2'h0)
      begin
         pend <= pend - 2'h1;
         mvalid <= (pend == 2'h1);
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; only the watchdog bounds the wait for pready
   task automatic apb(input logic wr, input logic [7:0] idx, wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1)
         @(posedge i_clk);
      rdv = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [7:0] idx, exp, input string nm);
      apb(1'b0, idx, 8'h00);
      chk(nm, {8'h0, exp}, {8'h0, rdv});
   endtask

   // launch a trim and poll the start bit until it drops
   task automatic run_trim(input logic [7:0] cfg, input logic [15:0] reqs,
      input logic [7:0] st);
      logic [15:0] r0;
      apb(1'b1, IDX_STATUS, 8'h03);
      apb(1'b1, IDX_CFG, cfg);
      r0 = nreq;
      apb(1'b1, IDX_CTRL, 8'h01);
      rdv = 8'h01;
      while (rdv[0] !== 1'b0)
         apb(1'b0, IDX_CTRL, 8'h00);
      chk("requests", reqs, nreq - r0);
      rd(IDX_STATUS, st, "status");
   endtask

   task automatic end_of_test();
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      #(40 * 20000);
      mismatches++;
      end_of_test();
   end

   // main sequence
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      rd(IDX_AZ, 8'h00, "az reset");
      rd(IDX_CFG, 8'h04, "cfg reset");
      rd(IDX_CTRL, 8'h00, "ctrl reset");
      apb(1'b0, 8'h10, 8'h00);
      chk("slverr", 16'h1, {15'h0, er});
      foreach (azt[i])
      begin
         apb(1'b1, IDX_AZ, azt[i][23:16]);
         a0 = azc;
         repeat (azt[i][15:8])
         begin
            cyc <= 1'b1;
            @(posedge i_clk);
            cyc <= 1'b0;
            @(posedge i_clk);
         end
         repeat (2) @(posedge i_clk);
         chk("autozero", {8'h0, azt[i][7:0]}, azc - a0);
      end
      apb(1'b1, IDX_IRQ_EN, 8'h01);
      run_trim(8'h51, 16'd10, 8'h03);
      chk("electrical", 16'h1, {15'h0, elec_seen});
      chk("irq", 16'h1, {15'h0, irq});
      foreach (offx[i])
         rd(IDX_OFFSET_FIRST + 8'(i), offx[i], "offset");
      rd(IDX_BASELINE_LO, 8'h09, "baseline");
      chk("baseline port", 16'h0009, base);
      chk("offset port", 16'h01FE, {7'h00, offs[0]});
      chk("offset port", 16'h00FF, {7'h00, offs[3]});
      run_trim(8'h08, 16'd0, 8'h01);
      apb(1'b1, IDX_IRQ_EN, 8'h00);
      chk("irq masked", 16'h0, {15'h0, irq});
      run_trim(8'h09, 16'd2, 8'h01);
      run_trim(8'h03, 16'd16, 8'h01);
      chk("optical", 16'h0, {15'h0, elec_seen});
      apb(1'b1, IDX_STATUS, 8'h03);
      apb(1'b1, IDX_CFG, 8'h07);
      apb(1'b1, IDX_CTRL, 8'h01);
      repeat (20) @(posedge i_clk);
      apb(1'b1, IDX_CTRL, 8'h00);
      rd(IDX_CTRL, 8'h00, "ctrl abort");
      a0 = nreq;
      repeat (40) @(posedge i_clk);
      chk("stopped", a0, nreq);
      rd(IDX_STATUS, 8'h00, "status abort");
      end_of_test();
   end
endmodule

//--- verif/trim_seq_chk.sv
// port checker for the offset trim sequencer
`timescale 1ns/1ps
module trim_seq_chk
   import trim_pkg::*;
#(
   parameter logic [13:0] SEARCH_TARGET = 14'h0100
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [9:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic i_cycle_start,
   input wire logic i_meas_valid,
   input wire logic [3:0][13:0] i_meas_chan,
   input wire logic [15:0] i_meas_prox,
   input wire logic o_meas_req,
   input wire logic o_meas_electrical,
   input wire logic [3:0][8:0] o_offset,
   input wire logic [15:0] o_baseline,
   input wire logic o_autozero,
   input wire logic o_trim_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // autozero is a lone pulse caused by a cycle tick
   chk_az_single: assert property (o_autozero |=> !o_autozero)
      else $error("autozero pulse longer than one cycle");
   chk_az_cause: assert property (o_autozero |-> $past(i_cycle_start))
      else $error("autozero without a cycle tick");
   // no back to back requests, offsets held in the cycle after a request
   chk_req_single: assert property (o_meas_req |=> !o_meas_req)
      else $error("back to back measurement requests");
   chk_off_hold: assert property (o_meas_req |=> $stable(o_offset))
      else $error("offsets moved during a measurement");
   chk_off_range: assert property (o_offset[0] != 9'h100 &&
      o_offset[1] != 9'h100 && o_offset[2] != 9'h100 &&
      o_offset[3] != 9'h100) else $error("offset below the floor");
   chk_base_cause: assert property ($changed(o_baseline) |->
      $past(i_meas_valid) || $past(i_meas_valid, 2) ||
      $past(i_meas_valid, 3)) else $error("baseline moved without data");
   chk_irq_fall: assert property ($fell(o_trim_irq) |->
      $past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2))
      else $error("trim irq dropped without a write");
   chk_elec_cause: assert property ($changed(o_meas_electrical) |->
      $past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2))
      else $error("electrical mode changed without a write");
endmodule
bind prox_offset_trim_sequencer trim_seq_chk
   #(.SEARCH_TARGET(SEARCH_TARGET)) trim_seq_chk_inst (.i_clk(i_clk),
   .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
   .i_cycle_start(i_cycle_start), .i_meas_valid(i_meas_valid),
   .i_meas_chan(i_meas_chan), .i_meas_prox(i_meas_prox),
   .o_meas_req(o_meas_req), .o_meas_electrical(o_meas_electrical),
   .o_offset(o_offset), .o_baseline(o_baseline),
   .o_autozero(o_autozero), .o_trim_irq(o_trim_irq));
